// ===== verilog/otp_lock_pkg.sv
// package: opcodes, address fields and timing for the otp and lock command block
package otp_lock_pkg;
	localparam logic [7:0] OP_NONE          = 8'h00;
	localparam logic [7:0] OP_WRITE_PERMIT  = 8'h06;
	localparam logic [7:0] OP_WRITE_FORBID  = 8'h04;
	localparam logic [7:0] OP_READ_SECREG   = 8'h48;
	localparam logic [7:0] OP_PROG_SECREG   = 8'h42;
	localparam logic [7:0] OP_ERASE_SECREG  = 8'h44;
	localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7e;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_LOCK_ONE      = 8'h36;
	localparam logic [7:0] OP_UNLOCK_ONE    = 8'h39;
	localparam logic [7:0] OP_READ_LOCK     = 8'h3d;
	localparam logic [7:0] OP_ADDR32_ON     = 8'hb7;
	localparam logic [7:0] OP_ADDR32_OFF    = 8'he9;
	localparam logic [5:0] LAST_BYTE_BIT    = 6'h07;
	localparam logic [5:0] LAST_ADDR3_BIT   = 6'h17;
	localparam logic [5:0] LAST_ADDR4_BIT   = 6'h1f;
	localparam int         SEL_HI           = 13;
	localparam int         SEL_LO           = 12;
	localparam int         GAP_HI           = 11;
	localparam int         GAP_LO           = 10;
	localparam int         OFF_W            = 10;
	localparam logic [1:0] SEL_ONE          = 2'h1;
	localparam logic [1:0] SEL_TWO          = 2'h2;
	localparam logic [1:0] GAP_OK           = 2'h0;
	localparam int         LOCK_LSB         = 16;
	localparam int         LOCK_W           = 10;
	localparam int         LOCK_COUNT       = 1024;
	localparam int         PAGE_W           = 8;
	localparam int         FIFO_W           = 16;
	localparam int         FIFO_DEPTH       = 16;
	localparam int         CLK_MHZ          = 20;
	localparam logic [7:0] ERASED_BYTE      = 8'hff;
	localparam logic       STATUS22_RESET   = 1'h1;
	typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_IGNORE} phase_t;
	typedef enum logic [1:0] {CY_IDLE, CY_PROG, CY_ERASE} cycle_t;
endpackage

// ===== verilog/otp_lock_cmds.sv
// otp security registers and block lock command logic of a serial flash
`timescale 1ns/1ps
`default_nettype none

module fifo_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
	logic [AW:0]      count_ff, nxt_count;
	logic             doPush, doPop;

	assign inReady  = count_ff != (AW+1)'(DEPTH);
	assign outValid = count_ff != '0;
	assign outData  = store[rdPtr_ff];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always_comb begin
		nxt_wrPtr = doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
		nxt_rdPtr = doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
		nxt_count = count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
	end

	always_ff @(posedge clk) begin
		if (doPush) begin
			store[wrPtr_ff] <= inData;
		end
	end
endmodule

// Behaviour
// - read secreg: opcode 48h, address, one dummy byte, all taken on rising sclk
// - read data leaves on falling sclk from any start byte, address then increments
// - read offset wraps from last byte to zero until chip select rises
// - address bits 13-12 pick register one or two, 11-10 zero, 9-0 offset
// - addresses are three bytes, four bytes while wide addressing is on
// - program secreg: opcode 42h, address, one to 256 data bytes
// - program cycle starts when chip select rises after the command
// - busy flag high during the cycle; write latch cleared before its end
// - a set register lock bit makes program of that register ignored
// - erase secreg 44h clears a whole 1024-byte register, offset ignored
// - erase needs its full opcode before chip select rises, else ignored
// - erase cycle starts at chip select rise, busy flag high throughout
// - erase of a register with its lock bit set is ignored
// - 7eh sets every block lock bit, 98h clears them all
// - lock bits protect only with sector select set, else range bits decide
// - block lock bits are volatile and come up as ones after reset
// - 36h locks and 39h unlocks the block at the given address
// - 3dh with an address returns a byte whose lsb is the lock bit
// - delivered state: all bytes erased, status bit twenty-two set
// - b7h turns wide addressing on, e9h or reset turns it off
module otp_lock_cmds
	import otp_lock_pkg::*;
#(
	parameter int PROG_TIME_US  = 500,
	parameter int ERASE_TIME_US = 1000
) (
	input  wire logic                                  sys_clk,
	input  wire logic                                  reset_n,
	input  wire logic                                  csN,
	input  wire logic                                  sclk,
	input  wire logic                                  si,
	output logic                                       so,
	output logic                                       soEn,
	input  wire logic                                  secregOneLockBit,
	input  wire logic                                  secregTwoLockBit,
	input  wire logic                                  perSectorProtectSelect,
	input  wire logic                                  protectRangeHit,
	input  wire logic [otp_lock_pkg::LOCK_W-1:0]       lockQueryIdx,
	output logic                                       queryProtected,
	output logic                                       writeInProgressFlag,
	output logic                                       writeLatchFlag,
	output logic                                       addrWidthFlag,
	output logic                                       statusBitTwentyTwo
);
	import otp_lock_pkg::*;

	localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

	function automatic logic selOk(input logic [31:0] a);
		return (a[SEL_HI:SEL_LO] == SEL_ONE || a[SEL_HI:SEL_LO] == SEL_TWO)
			&& a[GAP_HI:GAP_LO] == GAP_OK;
	endfunction

	// --------------------------------------------------------------
	// pin synchronisers and edge finders
	// --------------------------------------------------------------
	logic sclkS1_ff, sclkS2_ff, sclkPrev_ff;
	logic csS1_ff, csS2_ff, csPrev_ff;
	logic siS1_ff, siS2_ff;
	logic sclkRise, sclkFall, csRise;

	always_ff @(posedge sys_clk) begin
		sclkS1_ff   <= sclk;
		sclkS2_ff   <= sclkS1_ff;
		sclkPrev_ff <= sclkS2_ff;
		csS1_ff     <= csN;
		csS2_ff     <= csS1_ff;
		csPrev_ff   <= csS2_ff;
		siS1_ff     <= si;
		siS2_ff     <= siS1_ff;
	end

	assign sclkRise = sclkS2_ff && !sclkPrev_ff;
	assign sclkFall = !sclkS2_ff && sclkPrev_ff;
	assign csRise   = csS2_ff && !csPrev_ff;

	// --------------------------------------------------------------
	// command state
	// --------------------------------------------------------------
	phase_t                phase_ff, nxt_phase;
	cycle_t                cyc_ff, nxt_cyc;
	logic [7:0]            op_ff, nxt_op;
	logic [31:0]           sh_ff, nxt_sh, addr_ff, nxt_addr;
	logic [5:0]            bitCnt_ff, nxt_bitCnt;
	logic [2:0]            outBit_ff, nxt_outBit;
	logic                  so_ff, nxt_so, soEn_ff, nxt_soEn;
	logic                  wel_ff, nxt_wel, ads_ff, nxt_ads;
	logic                  wip_ff, nxt_wip, qProt_ff, nxt_qProt;
	logic [LOCK_COUNT-1:0] lock_ff, nxt_lock;
	logic [31:0]           timer_ff, nxt_timer;
	logic [OFF_W-1:0]      idx_ff, nxt_idx;
	logic                  loopDone_ff, nxt_loopDone;
	logic                  tSel_ff, nxt_tSel;
	logic                  s22_ff, nxt_s22;
	logic [1:0]            tHi_ff, nxt_tHi;
	logic                  gotData_ff, nxt_gotData;
	logic [7:0]            progPtr_ff, nxt_progPtr;
	logic                  pushV_ff, nxt_pushV;
	logic [FIFO_W-1:0]     pushW_ff, nxt_pushW;
	logic [255:0]          mask_ff, nxt_mask;
	logic                  fifoInReady, popValid, copying;
	logic [FIFO_W-1:0]     popWord;
	logic [7:0]            memRd_ff, outByte, pageBuf [256];
	// array comes up erased, as a delivered part would
	logic [7:0]            mem [2*LOCK_COUNT] = '{default: ERASED_BYTE};
	logic [7:0]            opFull;
	logic [31:0]           addrFull;
	logic                  regLocked, progOk, eraseOk;

	assign opFull    = {sh_ff[6:0], siS2_ff};
	assign addrFull  = {sh_ff[30:0], siS2_ff};
	assign regLocked = addr_ff[SEL_HI] ? secregTwoLockBit : secregOneLockBit;
	// the host sets the latch beforehand; here only its value counts
	assign progOk    = phase_ff == ST_DIN && op_ff == OP_PROG_SECREG && gotData_ff
		&& wel_ff && selOk(addr_ff) && !regLocked;
	assign eraseOk   = phase_ff == ST_IGNORE && op_ff == OP_ERASE_SECREG
		&& wel_ff && selOk(addr_ff) && !regLocked;
	assign copying   = cyc_ff == CY_PROG && !loopDone_ff && !popValid && !pushV_ff;
	assign outByte   = op_ff == OP_READ_LOCK
		? {7'h00, lock_ff[addr_ff[LOCK_LSB +: LOCK_W]]} : memRd_ff;

	always_comb begin
		nxt_phase = phase_ff; nxt_cyc = cyc_ff; nxt_op = op_ff;
		nxt_sh = sh_ff; nxt_addr = addr_ff; nxt_bitCnt = bitCnt_ff;
		nxt_outBit = outBit_ff; nxt_so = so_ff; nxt_soEn = soEn_ff;
		nxt_wel = wel_ff; nxt_ads = ads_ff; nxt_lock = lock_ff;
		nxt_timer = timer_ff; nxt_idx = idx_ff; nxt_loopDone = loopDone_ff;
		nxt_tSel = tSel_ff; nxt_tHi = tHi_ff; nxt_gotData = gotData_ff;
		nxt_progPtr = progPtr_ff; nxt_pushV = pushV_ff; nxt_pushW = pushW_ff;
		nxt_mask = mask_ff;
		nxt_s22 = s22_ff;
		if (pushV_ff && fifoInReady) begin
			nxt_pushV = 1'b0;
		end
		if (popValid && !copying) begin
			nxt_mask[popWord[15:8]] = 1'b1;
		end
		if (csS2_ff) begin
			nxt_phase  = ST_OPCODE;
			nxt_bitCnt = '0;
			nxt_outBit = '0;
			nxt_soEn   = 1'b0;
		end else if (sclkRise) begin
			nxt_sh     = addrFull;
			nxt_bitCnt = bitCnt_ff + 6'h01;
			case (phase_ff)
				ST_OPCODE: begin
					if (bitCnt_ff == LAST_BYTE_BIT) begin
						nxt_bitCnt  = '0;
						nxt_op      = wip_ff ? OP_NONE : opFull;
						nxt_gotData = 1'b0;
						nxt_phase   = ST_IGNORE;
						if (opFull == OP_PROG_SECREG) begin
							nxt_mask = '0;
						end
						if (!wip_ff && (opFull == OP_READ_SECREG || opFull == OP_PROG_SECREG
							|| opFull == OP_ERASE_SECREG || opFull == OP_LOCK_ONE
							|| opFull == OP_UNLOCK_ONE || opFull == OP_READ_LOCK)) begin
							nxt_phase = ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (bitCnt_ff == (ads_ff ? LAST_ADDR4_BIT : LAST_ADDR3_BIT)) begin
						nxt_bitCnt  = '0;
						nxt_addr    = ads_ff ? addrFull : {8'h00, addrFull[23:0]};
						nxt_progPtr = addrFull[7:0];
						case (op_ff)
							OP_READ_SECREG: nxt_phase = ST_DUMMY;
							OP_PROG_SECREG: nxt_phase = ST_DIN;
							OP_READ_LOCK:   nxt_phase = ST_DOUT;
							default:        nxt_phase = ST_IGNORE;
						endcase
					end
				end
				ST_DUMMY: begin
					if (bitCnt_ff == LAST_BYTE_BIT) begin
						nxt_bitCnt = '0;
						nxt_phase  = ST_DOUT;
					end
				end
				ST_DIN: begin
					if (bitCnt_ff == LAST_BYTE_BIT) begin
						nxt_bitCnt  = '0;
						nxt_pushV   = 1'b1;
						nxt_pushW   = {progPtr_ff, opFull};
						nxt_progPtr = progPtr_ff + 8'h01;
						nxt_gotData = 1'b1;
					end
				end
				default: nxt_bitCnt = '0;
			endcase
		end else if (sclkFall && phase_ff == ST_DOUT) begin
			nxt_so     = outByte[3'h7 - outBit_ff];
			nxt_soEn   = 1'b1;
			nxt_outBit = outBit_ff + 3'h1;
			if (outBit_ff == 3'h7) begin
				nxt_addr[OFF_W-1:0] = addr_ff[OFF_W-1:0] + 10'h001;
			end
		end
		if (csRise && (progOk || eraseOk)) begin
			nxt_cyc      = progOk ? CY_PROG : CY_ERASE;
			nxt_timer    = '0;
			nxt_idx      = '0;
			nxt_loopDone = 1'b0;
			nxt_tSel     = addr_ff[SEL_HI];
			nxt_tHi      = addr_ff[9:8];
			nxt_wel      = 1'b0;
		end else if (csRise && phase_ff == ST_IGNORE) begin
			case (op_ff)
				OP_WRITE_PERMIT:  nxt_wel = 1'b1;
				OP_WRITE_FORBID:  nxt_wel = 1'b0;
				OP_ADDR32_ON:     nxt_ads = 1'b1;
				OP_ADDR32_OFF:    nxt_ads = 1'b0;
				OP_GLOBAL_LOCK:   nxt_lock = '1;
				OP_GLOBAL_UNLOCK: nxt_lock = '0;
				OP_LOCK_ONE:      nxt_lock[addr_ff[LOCK_LSB +: LOCK_W]] = 1'b1;
				OP_UNLOCK_ONE:    nxt_lock[addr_ff[LOCK_LSB +: LOCK_W]] = 1'b0;
				default:          nxt_wel = wel_ff;
			endcase
		end else if (cyc_ff != CY_IDLE) begin
			nxt_timer = timer_ff + 32'h1;
			if (cyc_ff == CY_ERASE || copying) begin
				nxt_idx = idx_ff + 10'h001;
				if (idx_ff == (cyc_ff == CY_ERASE ? {OFF_W{1'b1}} : OFF_W'((1 << PAGE_W) - 1))) begin
					nxt_loopDone = 1'b1;
				end
			end
			if (loopDone_ff && timer_ff >= 32'(cyc_ff == CY_ERASE ? ERASE_CYCLES : PROG_CYCLES)) begin
				nxt_cyc = CY_IDLE;
			end
		end
		nxt_wip   = nxt_cyc != CY_IDLE;
		nxt_qProt = perSectorProtectSelect ? lock_ff[lockQueryIdx] : protectRangeHit;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			phase_ff <= ST_OPCODE; cyc_ff <= CY_IDLE; op_ff <= OP_NONE;
			sh_ff <= '0; addr_ff <= '0; bitCnt_ff <= '0; outBit_ff <= '0;
			so_ff <= 1'b0; soEn_ff <= 1'b0; wel_ff <= 1'b0;
			ads_ff <= 1'b0;
			wip_ff <= 1'b0; qProt_ff <= 1'b0;
			lock_ff <= '1;
			timer_ff <= '0; idx_ff <= '0; loopDone_ff <= 1'b1;
			tSel_ff <= 1'b0; tHi_ff <= '0; gotData_ff <= 1'b0;
			progPtr_ff <= '0; pushV_ff <= 1'b0; pushW_ff <= '0; mask_ff <= '0;
			s22_ff <= STATUS22_RESET;
		end else begin
			phase_ff <= nxt_phase; cyc_ff <= nxt_cyc; op_ff <= nxt_op;
			sh_ff <= nxt_sh; addr_ff <= nxt_addr; bitCnt_ff <= nxt_bitCnt;
			outBit_ff <= nxt_outBit; so_ff <= nxt_so; soEn_ff <= nxt_soEn;
			wel_ff <= nxt_wel; ads_ff <= nxt_ads; wip_ff <= nxt_wip;
			qProt_ff <= nxt_qProt; lock_ff <= nxt_lock; timer_ff <= nxt_timer;
			idx_ff <= nxt_idx; loopDone_ff <= nxt_loopDone; tSel_ff <= nxt_tSel;
			tHi_ff <= nxt_tHi; gotData_ff <= nxt_gotData; progPtr_ff <= nxt_progPtr;
			pushV_ff <= nxt_pushV; pushW_ff <= nxt_pushW; mask_ff <= nxt_mask;
			s22_ff <= nxt_s22;
		end
	end

	// --------------------------------------------------------------
	// data path: byte fifo, page buffer, register array
	// --------------------------------------------------------------
	// the copy into the array stalls the drain so the buffer cannot change under it
	fifo_buf #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) byteFifo (
		.clk      (sys_clk),
		.reset_n  (reset_n),
		.inValid  (pushV_ff),
		.inReady  (fifoInReady),
		.inData   (pushW_ff),
		.outValid (popValid),
		.outReady (!copying),
		.outData  (popWord)
	);

	always_ff @(posedge sys_clk) begin
		memRd_ff <= mem[{addr_ff[SEL_HI], addr_ff[OFF_W-1:0]}];
		if (popValid && !copying) begin
			pageBuf[popWord[15:8]] <= popWord[7:0];
		end
		if (cyc_ff == CY_ERASE && !loopDone_ff) begin
			mem[{tSel_ff, idx_ff}] <= ERASED_BYTE;
		end else if (copying && mask_ff[idx_ff[7:0]]) begin
			mem[{tSel_ff, tHi_ff, idx_ff[7:0]}] <=
				mem[{tSel_ff, tHi_ff, idx_ff[7:0]}] & pageBuf[idx_ff[7:0]];
		end
	end

	assign so                  = so_ff;
	assign soEn                = soEn_ff;
	assign queryProtected      = qProt_ff;
	assign writeInProgressFlag = wip_ff;
	assign writeLatchFlag      = wel_ff;
	assign addrWidthFlag       = ads_ff;
	assign statusBitTwentyTwo  = s22_ff;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_prog_starts: assert property (csRise && progOk |=> wip_ff && !wel_ff)
		else $error("program cycle did not start");
	a_erase_starts: assert property (csRise && eraseOk |=> wip_ff ##1 wip_ff)
		else $error("erase cycle did not start");
	a_locked_erase: assert property (!wip_ff && csRise && op_ff == OP_ERASE_SECREG
		&& regLocked |=> !wip_ff)
		else $error("locked register erased");
	a_locked_prog: assert property (!wip_ff && csRise && op_ff == OP_PROG_SECREG
		&& regLocked |=> !wip_ff)
		else $error("locked register programmed");
	a_latch_needed: assert property (!wip_ff && csRise && !wel_ff |=> !wip_ff)
		else $error("cycle started without write latch");
	a_early_cs: assert property (!wip_ff && csRise && phase_ff == ST_OPCODE
		|=> !wip_ff && $stable(lock_ff))
		else $error("short command executed");
	a_read_wrap: assert property (sclkFall && phase_ff == ST_DOUT && !csS2_ff
		&& outBit_ff == 3'h7 && addr_ff[9:0] == 10'h3ff |=> addr_ff[9:0] == 10'h000)
		else $error("read offset did not wrap");
	a_global_lock: assert property (csRise && phase_ff == ST_IGNORE
		&& op_ff == OP_GLOBAL_LOCK && !progOk |=> &lock_ff)
		else $error("global lock missed");
	a_wide_addr: assert property (csRise && phase_ff == ST_IGNORE
		&& op_ff == OP_ADDR32_ON |=> addrWidthFlag)
		else $error("wide addressing not entered");

	c_erase: cover property (csRise && eraseOk);
	c_prog: cover property (csRise && progOk);
	c_wrap: cover property (sclkFall && phase_ff == ST_DOUT && addr_ff[9:0] == 10'h3ff);
	c_lock_read: cover property (phase_ff == ST_DOUT && op_ff == OP_READ_LOCK && soEn_ff);
endmodule

`default_nettype wire

// ===== test/spi_host_model.sv
// serial bus host model that frames commands for the flash command block
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input  wire logic sys_clk,
	output logic      csN,
	output logic      sclk,
	output logic      si,
	input  wire logic so
);
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// si moves only while sclk is low, so it is steady at the rise
	// so is read mid-high: the device only moves it a few clocks after a fall
	task automatic bit_cycle(input logic b, output logic r);
		si = b;
		wait_clk(4);
		sclk = 1'b1;
		wait_clk(2);
		r = so;
		wait_clk(2);
		sclk = 1'b0;
	endtask

	// sclk stands low between frames; si flips after release so no stale level lingers
	task automatic frame(input logic [7:0] tx[$], input int nbits, input int nrd,
			output logic [7:0] rx[$]);
		logic       r;
		logic [7:0] b;
		rx = {};
		b = 8'h00;
		wait_clk(1);
		csN = 1'b0;
		for (int i = 0; i < nbits; i++) bit_cycle(tx[i/8][7-i%8], r);
		for (int i = 0; i < nrd * 8; i++) begin
			bit_cycle(i[0], r);
			b = {b[6:0], r};
			if (i % 8 == 7) rx.push_back(b);
		end
		wait_clk(4);
		csN = 1'b1;
		si = ~si;
		wait_clk(8);
	endtask
endmodule

`default_nettype wire

// ===== test/otp_secreg_and_sector_lock_cmds_tb_top.sv
// self-checking bench for the otp security register and block lock command block
`timescale 1ns/1ps
`default_nettype none

module otp_secreg_and_sector_lock_cmds_tb_top;
	import otp_lock_pkg::*;
	// shortened self-timed cycles keep the run small
	localparam int T_US = 60;
	logic              sys_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              csN, sclk, si, so, soEn;
	logic              secregOneLockBit = 1'b0, secregTwoLockBit = 1'b0;
	logic              perSectorProtectSelect = 1'b1, protectRangeHit = 1'b0;
	logic [LOCK_W-1:0] lockQueryIdx = '0;
	logic              queryProtected, writeInProgressFlag, writeLatchFlag;
	logic              addrWidthFlag, statusBitTwentyTwo;
	logic [31:0]       seed = 32'h46f6;
	logic [7:0]        mem [2][1024] = '{default: 8'hff};
	logic              lk [LOCK_COUNT];
	logic              write_latch_flag, addr_width_flag;
	int                error_cnt = 0, n_tests = 0;

	always #25 sys_clk = ~sys_clk;

	otp_lock_cmds #(.PROG_TIME_US(T_US), .ERASE_TIME_US(T_US)) i_dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .csN(csN), .sclk(sclk), .si(si), .so(so), .soEn(soEn),
		.secregOneLockBit(secregOneLockBit), .secregTwoLockBit(secregTwoLockBit),
		.perSectorProtectSelect(perSectorProtectSelect), .protectRangeHit(protectRangeHit),
		.lockQueryIdx(lockQueryIdx), .queryProtected(queryProtected),
		.writeInProgressFlag(writeInProgressFlag), .writeLatchFlag(writeLatchFlag),
		.addrWidthFlag(addrWidthFlag), .statusBitTwentyTwo(statusBitTwentyTwo));
	// a released output shows the inverse of its last bit, so a late enable is caught
	spi_host_model i_host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .si(si),
		.so(soEn ? so : !so));

	// ---------------------------------------------------------------
	// reference model and helper tasks
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] sa(input int s, input int off);
		return (32'(s + 1) << 12) | 32'(off & 1023);
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		tick(16);
		reset_n = 1'b1;
		foreach (lk[i]) lk[i] = 1'b1;
		write_latch_flag = 1'b0;
		addr_width_flag = 1'b0;
		tick(4);
	endtask

	task automatic send(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
			input int cut, input int nrd, output logic [7:0] tx[$], output logic [7:0] rx[$]);
		tx = {op};
		for (int i = na - 1; i >= 0; i--) tx.push_back(a[8*i+:8]);
		for (int i = 0; i < nd; i++) tx.push_back(8'(rnd()));
		i_host.frame(tx, (cut > 0) ? cut : tx.size() * 8, nrd, rx);
	endtask

	task automatic bare(input logic [7:0] op);
		logic [7:0] tx[$], rx[$];
		send(op, 32'h0, 0, 0, 0, 0, tx, rx);
		case (op)
			OP_WRITE_PERMIT: write_latch_flag = 1'b1;
			OP_WRITE_FORBID: write_latch_flag = 1'b0;
			OP_ADDR32_ON: addr_width_flag = 1'b1;
			OP_ADDR32_OFF: addr_width_flag = 1'b0;
			OP_GLOBAL_LOCK: foreach (lk[i]) lk[i] = 1'b1;
			OP_GLOBAL_UNLOCK: foreach (lk[i]) lk[i] = 1'b0;
			default: ;
		endcase
		chk_bit("write latch", write_latch_flag, writeLatchFlag);
		chk_bit("wide address", addr_width_flag, addrWidthFlag);
	endtask

	task automatic wr(input logic [7:0] op, input logic [31:0] a, input int nd, input int cut);
		logic [7:0] tx[$], rx[$];
		int         s, na, n;
		bit         ok;
		na = addr_width_flag ? 4 : 3;
		s = int'(a[13:12]) - 1;
		ok = write_latch_flag && a[11:10] == GAP_OK && cut == 0;
		ok = ok && (a[13:12] == SEL_ONE || a[13:12] == SEL_TWO);
		if (ok) ok = (s == 0) ? !secregOneLockBit : !secregTwoLockBit;
		send(op, a, na, nd, cut, 0, tx, rx);
		if (!ok) begin
			tick(4);
			chk_bit("ignored busy", 1'b0, writeInProgressFlag);
			return;
		end
		write_latch_flag = 1'b0;
		for (int i = 0; i < 1024; i++) begin
			if (op == OP_ERASE_SECREG) mem[s][i] = 8'hff;
			else if (i < nd) mem[s][{a[9:8], 8'(a[7:0] + i)}] &= tx[na + 1 + i];
		end
		n = 0;
		while (writeInProgressFlag !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk_bit("busy", 1'b1, writeInProgressFlag);
		chk_bit("latch cleared", 1'b0, writeLatchFlag);
		n = 0;
		while (writeInProgressFlag !== 1'b0 && n < 4000) begin
			tick(1);
			n++;
		end
		chk_bit("busy ends", 1'b0, writeInProgressFlag);
		chk_bit("busy length", 1'b1, n > T_US * CLK_MHZ - 20);
		if (n >= 4000) print_verdict();
	endtask

	task automatic rd_chk(input int s, input int off, input int n);
		logic [7:0] tx[$], rx[$];
		send(OP_READ_SECREG, sa(s, off), addr_width_flag ? 4 : 3, 1, 0, n, tx, rx);
		for (int i = 0; i < n; i++)
			chk_val("secreg byte", mem[s][(off + i) % 1024], rx[i]);
		chk_bit("output enable", 1'b0, soEn);
	endtask

	task automatic lk1(input logic [7:0] op, input int idx);
		logic [7:0] tx[$], rx[$];
		send(op, 32'(idx) << 16, addr_width_flag ? 4 : 3, 0, 0, 0, tx, rx);
		lk[idx] = (op == OP_LOCK_ONE);
	endtask

	task automatic lkq(input int idx);
		logic [7:0] tx[$], rx[$];
		send(OP_READ_LOCK, 32'(idx) << 16, addr_width_flag ? 4 : 3, 0, 0, 2, tx, rx);
		for (int i = 0; i < 2; i++) chk_val("lock byte", {7'h0, lk[idx]}, rx[i]);
		lockQueryIdx = LOCK_W'(idx);
		tick(2);
		chk_bit("query", perSectorProtectSelect ? lk[idx] : protectRangeHit, queryProtected);
	endtask

	// page data streams through the byte fifo ahead of the page buffer
	task automatic fifo_test();
		logic [7:0] tx[$], rx[$];
		int         off, n;
		off = int'(rnd() % 1024);
		n = FIFO_DEPTH + 4;
		bare(OP_WRITE_PERMIT);
		bare(OP_WRITE_FORBID);
		wr(OP_PROG_SECREG, sa(1, off), n, 0);
		bare(OP_WRITE_PERMIT);
		wr(OP_PROG_SECREG, sa(1, off), n, 0);
		send(OP_READ_SECREG, sa(1, off), 3, 1, 0, n, tx, rx);
		chk_val("fifo byte count", n, rx.size());
		for (int i = 0; i < n; i++)
			chk_val("fifo word", mem[1][(off + i) % 1024], rx[i]);
		chk_bit("fifo drained", 1'b0, writeInProgressFlag);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		int idx, off;
		do_reset();
		chk_bit("busy", 1'b0, writeInProgressFlag);
		chk_bit("wide address", 1'b0, addrWidthFlag);
		chk_bit("status bit", 1'b1, statusBitTwentyTwo);
		lkq(int'(rnd() % 256));
		for (int s = 0; s < 2; s++) rd_chk(s, int'(rnd() % 1024), 2);
		$display("test reset done, %0d mismatches", error_cnt);
		wr(OP_PROG_SECREG, sa(0, 10'h3fe), 3, 0);
		bare(OP_WRITE_PERMIT);
		wr(OP_PROG_SECREG, sa(0, 10'h3fe), 3, 0);
		rd_chk(0, 10'h3fe, 4);
		rd_chk(0, 10'h300, 1);
		bare(OP_WRITE_PERMIT);
		off = int'(rnd() % 1024);
		wr(OP_PROG_SECREG, sa(1, off), 256, 0);
		rd_chk(1, off, 3);
		$display("test program done, %0d mismatches", error_cnt);
		bare(OP_WRITE_PERMIT);
		wr(OP_PROG_SECREG, sa(0, 5) | 32'h400, 1, 0);
		wr(OP_PROG_SECREG, 32'h3005, 1, 0);
		secregOneLockBit = 1'b1;
		wr(OP_PROG_SECREG, sa(0, 5), 1, 0);
		wr(OP_ERASE_SECREG, sa(0, 0), 0, 0);
		secregOneLockBit = 1'b0;
		secregTwoLockBit = 1'b1;
		wr(OP_PROG_SECREG, sa(1, 5), 1, 0);
		secregTwoLockBit = 1'b0;
		wr(OP_ERASE_SECREG, sa(0, 0), 0, 6);
		wr(OP_ERASE_SECREG, sa(0, 10'h2a7), 0, 0);
		rd_chk(0, 10'h3fe, 3);
		rd_chk(1, off, 2);
		$display("test refusal and erase done, %0d mismatches", error_cnt);
		bare(OP_ADDR32_ON);
		bare(OP_WRITE_PERMIT);
		wr(OP_PROG_SECREG, sa(1, 10'h010) | 32'hff00_0000, 2, 0);
		rd_chk(1, 10'h010, 2);
		idx = 10'h3a5 + int'(rnd() % 32);
		bare(OP_GLOBAL_UNLOCK);
		lkq(idx);
		lk1(OP_LOCK_ONE, idx);
		lkq(idx);
		lkq(idx - 1);
		bare(OP_GLOBAL_LOCK);
		lkq(idx - 1);
		lk1(OP_UNLOCK_ONE, idx);
		lkq(idx);
		perSectorProtectSelect = 1'b0;
		for (int i = 0; i < 2; i++) begin
			protectRangeHit = i[0];
			lkq(idx);
		end
		perSectorProtectSelect = 1'b1;
		bare(OP_ADDR32_OFF);
		$display("test wide address and locks done, %0d mismatches", error_cnt);
		bare(OP_GLOBAL_UNLOCK);
		bare(OP_ADDR32_ON);
		do_reset();
		chk_bit("wide address", 1'b0, addrWidthFlag);
		lkq(idx & 255);
		$display("test second reset done, %0d mismatches", error_cnt);
		fifo_test();
		$display("test fifo done, %0d mismatches", error_cnt);
		print_verdict();
	end
endmodule

`default_nettype wire
